/* hw/hpmc_duty_meter.sv */
// Purpose: measures duty cycle of the already synchronised stream pin
// Assumes: pin_i is on clk_i; fixed 256-cycle measuring window
// Notes: result updates once per window, so duty changes show with one window lag
`timescale 1ns/100ps
module hpmc_duty_meter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic [7:0] duty_o
);
  logic [7:0] win_reg;
  logic [8:0] high_reg;

  // window counter and high-time accumulation
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_reg <= 8'h00;
      high_reg <= 9'h000;
      duty_o <= 8'h00;
    end else if (ce_i) begin
      win_reg <= win_reg + 8'h01;
      if (win_reg == 8'hFF) begin
        // a full-high window would read 256, clip to the top code
        duty_o <= high_reg[8] ? 8'hFF : high_reg[7:0];
        high_reg <= {8'h00, pin_i};
      end else begin
        high_reg <= high_reg + {8'h00, pin_i};
      end
    end
  end
endmodule

/* hw/hpmc_pkg.sv */
// Purpose: shared constants and types of the haptic playback mode controller
// Assumes: 100 MHz clock, register map on a 32-bit classic Wishbone slave
// Notes: every offset and timing count lives here, with the ctrl, seq and stat field positions and the ctrl, thr and amp reset values
package hpmc_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AMP = 8'h04;
  localparam logic [7:0] ADDR_SEQ = 8'h08;
  localparam logic [7:0] ADDR_THR = 8'h0C;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam logic [7:0] ADDR_MEMCTL = 8'h18;
  localparam logic [7:0] ADDR_MEMADR = 8'h1C;
  localparam logic [7:0] ADDR_MEMDAT = 8'h20;
  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_STBY = 3;
  localparam int CTRL_ACCEL = 4;
  localparam int CTRL_TRACK = 5;
  localparam int CTRL_RSTOP = 6;
  localparam int CTRL_ERM = 7;
  // sequence word fields
  localparam int SEQ_ID_LSB = 0;
  localparam int SEQ_LOOP_LSB = 4;
  localparam int SEQ_GO = 8;
  localparam int SEQ_REP = 9;
  // status word fields
  localparam int STAT_FLAG = 0;
  localparam int STAT_INACT = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_DUTY_LSB = 8;
  // operating mode codes
  localparam logic [2:0] MODE_INACTIVE = 3'h0;
  localparam logic [2:0] MODE_DIRECT = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_REG_PLAY = 3'h3;
  localparam logic [2:0] MODE_PIN_PLAY = 3'h4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] THR_RST = 8'h10;
  localparam logic [7:0] AMP_RST = 8'h00;
  // pattern store geometry; base is where the first snippet slot lies
  localparam int MEM_DEPTH = 128;
  localparam int MEM_AW = 7;
  localparam logic [6:0] PATTERN_BASE = 7'h10;
  // amplitude codes
  localparam logic [7:0] DUTY_MID = 8'h80;
  localparam logic [7:0] FULL_UNSIGNED = 8'hFF;
  localparam logic [7:0] FULL_SIGNED = 8'h7F;
  // timing, times in microseconds, counts in clock cycles
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WAKE_TIME_US = 750;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
  localparam int unsigned BRAKE_TIME_US = 20;
  localparam int unsigned BRAKE_CYCLES = BRAKE_TIME_US * CLK_MHZ;
  localparam int unsigned STEP_TIME_US = 1000;
  localparam int unsigned STEP_CYCLES = STEP_TIME_US * CLK_MHZ;
  localparam int CNT_W = 17;
  typedef enum logic [1:0] {ST_IDLE, ST_STANDBY, ST_WAKE, ST_DRIVE} hpmc_state_t;
endpackage

/* hw/hpmc_top.sv */
// Purpose: playback mode controller of a haptic actuator driver
// Assumes: Wishbone classic slave, one 100 MHz clock, trigger pins asynchronous
// Notes: pattern store has no reset, nothing clears its contents, rst_i leaves them as they are
`timescale 1ns/100ps
module hpmc_top #(
  parameter int unsigned WAKE_CYCLES = hpmc_pkg::WAKE_CYCLES,
  parameter int unsigned STEP_CYCLES = hpmc_pkg::STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] trigger_pins_i,
  output logic [7:0] drive_level_o,
  output logic drive_en_o,
  output logic drive_signed_o,
  output logic lra_phase_flip_o,
  output logic erm_polarity_inv_o,
  output logic interrupt_out_n_o
);
  hpmc_pkg::hpmc_state_t state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] direct_amplitude;
  logic [3:0] selected_sequence_id;
  logic [3:0] selected_sequence_loops;
  logic playback_go;
  logic playback_repeat;
  logic [7:0] zero_drive_duty_threshold;
  logic playback_finished_flag;
  logic mask_reg;
  logic pattern_store_unlock;
  logic [6:0] mem_addr_reg;
  logic [7:0] mem [hpmc_pkg::MEM_DEPTH];
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] pins_last_reg;
  logic [16:0] wake_cnt_reg;
  logic [16:0] step_cnt_reg;
  logic [3:0] loops_left_reg;
  logic [16:0] brake_cnt_reg;
  logic [7:0] duty;
  logic [2:0] mode;
  logic standby_en, accel_en, track_en, rstop_en, erm_sel;
  logic wb_req, wr, wr0, wr1, mem_we, go_clr, rep_clr, done_evt, pin_edge, abort;
  logic [7:0] play_amp, pwm_amp, level_next;
  logic en_next;
  logic signed [8:0] duty_off;
  logic [7:0] duty_mag;
  hpmc_pkg::hpmc_state_t rest_state;

  // valid-mode decode used by both the state machine and the drive path
  function automatic logic is_playback(input logic [2:0] m);
    return (m == hpmc_pkg::MODE_REG_PLAY) || (m == hpmc_pkg::MODE_PIN_PLAY);
  endfunction
  function automatic logic is_stream(input logic [2:0] m);
    return (m == hpmc_pkg::MODE_DIRECT) || (m == hpmc_pkg::MODE_PWM);
  endfunction

  assign mode = ctrl_reg[hpmc_pkg::CTRL_MODE_LSB +: 3];
  assign standby_en = ctrl_reg[hpmc_pkg::CTRL_STBY];
  assign accel_en = ctrl_reg[hpmc_pkg::CTRL_ACCEL];
  assign track_en = ctrl_reg[hpmc_pkg::CTRL_TRACK];
  assign rstop_en = ctrl_reg[hpmc_pkg::CTRL_RSTOP];
  assign erm_sel = ctrl_reg[hpmc_pkg::CTRL_ERM];
  assign rest_state = standby_en ? hpmc_pkg::ST_STANDBY : hpmc_pkg::ST_IDLE;

  // bus strobes; writes land on the edge where ack rises
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_req && wb_we_i;
  assign wr0 = wr && wb_sel_i[0];
  assign wr1 = wr && wb_sel_i[1];
  assign mem_we = wr0 && (wb_adr_i == hpmc_pkg::ADDR_MEMDAT) && pattern_store_unlock;

  // pin synchronisers, two flops per trigger pin before anything looks
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          pins_last_reg[gi] <= 1'b0;
        end else if (ce_i) begin
          sync1_reg[gi] <= trigger_pins_i[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          pins_last_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate
  // rising edge on any trigger pin
  assign pin_edge = |(sync2_reg & ~pins_last_reg);

  // bit 0 of the trigger pins doubles as the stream input
  hpmc_duty_meter u_duty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(sync2_reg[0]),
    .duty_o(duty)
  );

  // stream duty to amplitude; threshold window gives zero drive
  assign duty_off = $signed({1'b0, duty}) - $signed({1'b0, hpmc_pkg::DUTY_MID});
  assign duty_mag = duty_off[8] ? 8'(-duty_off) : duty_off[7:0];
  always_comb begin
    if (accel_en) begin
      pwm_amp = (duty_mag <= zero_drive_duty_threshold) ? 8'h00 : duty_off[7:0];
    end else begin
      pwm_amp = (duty < zero_drive_duty_threshold) ? 8'h00 : duty;
    end
  end

  // control and sequence registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= hpmc_pkg::CTRL_RST;
      direct_amplitude <= hpmc_pkg::AMP_RST;
      zero_drive_duty_threshold <= hpmc_pkg::THR_RST;
      mask_reg <= 1'b0;
      pattern_store_unlock <= 1'b0;
      selected_sequence_id <= 4'h0;
      selected_sequence_loops <= 4'h0;
    end else if (ce_i && wr0) begin
      if (wb_adr_i == hpmc_pkg::ADDR_CTRL) begin
        ctrl_reg <= wb_dat_i[7:0];
      end else if (wb_adr_i == hpmc_pkg::ADDR_AMP) begin
        direct_amplitude <= wb_dat_i[7:0];
      end else if (wb_adr_i == hpmc_pkg::ADDR_THR) begin
        zero_drive_duty_threshold <= wb_dat_i[7:0];
      end else if (wb_adr_i == hpmc_pkg::ADDR_MASK) begin
        mask_reg <= wb_dat_i[0];
      end else if (wb_adr_i == hpmc_pkg::ADDR_MEMCTL) begin
        pattern_store_unlock <= wb_dat_i[0];
      end else if (wb_adr_i == hpmc_pkg::ADDR_SEQ) begin
        selected_sequence_id <= wb_dat_i[hpmc_pkg::SEQ_ID_LSB +: 4];
        selected_sequence_loops <= wb_dat_i[hpmc_pkg::SEQ_LOOP_LSB +: 4];
      end
    end
  end

  // go and repeat bits: host sets, hardware clears when consumed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      playback_go <= 1'b0;
      playback_repeat <= 1'b0;
    end else if (ce_i) begin
      if (wr1 && wb_adr_i == hpmc_pkg::ADDR_SEQ) begin
        playback_go <= wb_dat_i[hpmc_pkg::SEQ_GO];
        playback_repeat <= wb_dat_i[hpmc_pkg::SEQ_REP];
      end else begin
        // a pin edge in mode 4 arms go, else the drive would read as an abort
        if (go_clr) playback_go <= 1'b0;
        else if (mode == hpmc_pkg::MODE_PIN_PLAY && pin_edge) playback_go <= 1'b1;
        if (rep_clr) playback_repeat <= 1'b0;
      end
    end
  end

  // pattern store: no reset on purpose so contents survive soft resets
  always_ff @(posedge clk_i) begin
    if (ce_i && mem_we) begin
      mem[mem_addr_reg] <= wb_dat_i[7:0];
    end
  end

  // store address pointer, auto-increments on each accepted data write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_reg <= hpmc_pkg::PATTERN_BASE;
    end else if (ce_i) begin
      if (wr0 && wb_adr_i == hpmc_pkg::ADDR_MEMADR) begin
        mem_addr_reg <= wb_dat_i[6:0];
      end else if (mem_we) begin
        mem_addr_reg <= mem_addr_reg + 7'h01;
      end
    end
  end

  // one amplitude byte per sequence, indexed from the first snippet slot
  assign play_amp = mem[hpmc_pkg::PATTERN_BASE + {3'h0, selected_sequence_id}];

  // aborts: inactive or undefined mode, or go dropped during playback
  assign abort = !(is_stream(mode) || is_playback(mode))
    || (is_playback(mode) && !playback_go && state_reg == hpmc_pkg::ST_DRIVE);
  assign done_evt = ce_i && state_reg == hpmc_pkg::ST_DRIVE && is_playback(mode)
    && playback_go && !playback_repeat && loops_left_reg == 4'h0 && step_cnt_reg == 17'h0;
  assign go_clr = done_evt;
  assign rep_clr = state_reg == hpmc_pkg::ST_DRIVE && is_playback(mode) && playback_repeat;

  // mode state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= hpmc_pkg::ST_IDLE;
      wake_cnt_reg <= 17'h0;
    end else if (ce_i) begin
      case (state_reg)
        hpmc_pkg::ST_IDLE, hpmc_pkg::ST_STANDBY: begin
          state_reg <= rest_state;
          // playback modes wait for go, or a pin edge in mode 4
          if (is_stream(mode) || (is_playback(mode) && playback_go)
              || (mode == hpmc_pkg::MODE_PIN_PLAY && pin_edge)) begin
            state_reg <= hpmc_pkg::ST_WAKE;
            wake_cnt_reg <= 17'(WAKE_CYCLES - 1);
          end
        end
        hpmc_pkg::ST_WAKE: begin
          if (abort) begin
            state_reg <= rest_state;
          end else if (wake_cnt_reg == 17'h0) begin
            state_reg <= hpmc_pkg::ST_DRIVE;
          end else begin
            wake_cnt_reg <= wake_cnt_reg - 17'h1;
          end
        end
        hpmc_pkg::ST_DRIVE: begin
          if (abort || done_evt) begin
            state_reg <= rest_state;
          end
        end
        default: state_reg <= hpmc_pkg::ST_IDLE;
      endcase
    end
  end

  // playback loop and step counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loops_left_reg <= 4'h0;
      step_cnt_reg <= 17'h0;
    end else if (ce_i) begin
      if (state_reg != hpmc_pkg::ST_DRIVE || rep_clr) begin
        // repeat restarts the whole sequence from its first loop
        loops_left_reg <= selected_sequence_loops;
        step_cnt_reg <= 17'(STEP_CYCLES - 1);
      end else if (step_cnt_reg != 17'h0) begin
        step_cnt_reg <= step_cnt_reg - 17'h1;
      end else if (loops_left_reg != 4'h0) begin
        loops_left_reg <= loops_left_reg - 4'h1;
        step_cnt_reg <= 17'(STEP_CYCLES - 1);
      end
    end
  end

  // amplitude source per mode; zero keeps the state but gates the stage
  always_comb begin
    level_next = 8'h00;
    en_next = 1'b0;
    if (state_reg == hpmc_pkg::ST_DRIVE && !abort) begin
      if (mode == hpmc_pkg::MODE_DIRECT) begin
        level_next = direct_amplitude;
      end else if (mode == hpmc_pkg::MODE_PWM) begin
        level_next = pwm_amp;
      end else if (is_playback(mode)) begin
        level_next = play_amp;
      end
      en_next = level_next != 8'h00;
    end
  end

  // brake window: only when tracking runs, since braking relies on it;
  // a braking stage must not restart its own window, or it never ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brake_cnt_reg <= 17'h0;
    end else if (ce_i) begin
      if (rstop_en && track_en && drive_en_o && !en_next
          && !lra_phase_flip_o && !erm_polarity_inv_o) begin
        brake_cnt_reg <= 17'(hpmc_pkg::BRAKE_CYCLES);
      end else if (en_next) begin
        brake_cnt_reg <= 17'h0;
      end else if (brake_cnt_reg != 17'h0) begin
        brake_cnt_reg <= brake_cnt_reg - 17'h1;
      end
    end
  end

  // registered drive outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_level_o <= 8'h00;
      drive_en_o <= 1'b0;
      drive_signed_o <= 1'b0;
      lra_phase_flip_o <= 1'b0;
      erm_polarity_inv_o <= 1'b0;
    end else if (ce_i) begin
      drive_signed_o <= accel_en;
      if (brake_cnt_reg != 17'h0 && !en_next) begin
        // full reverse: phase flip on resonant, polarity swap on rotating
        drive_level_o <= accel_en ? hpmc_pkg::FULL_SIGNED : hpmc_pkg::FULL_UNSIGNED;
        drive_en_o <= 1'b1;
        lra_phase_flip_o <= !erm_sel;
        erm_polarity_inv_o <= erm_sel;
      end else begin
        drive_level_o <= level_next;
        drive_en_o <= en_next;
        lra_phase_flip_o <= 1'b0;
        erm_polarity_inv_o <= 1'b0;
      end
    end
  end

  // finished flag: set wins over a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      playback_finished_flag <= 1'b0;
      interrupt_out_n_o <= 1'b1;
    end else if (ce_i) begin
      if (done_evt) begin
        playback_finished_flag <= 1'b1;
      end else if (wr0 && wb_adr_i == hpmc_pkg::ADDR_STAT && wb_dat_i[hpmc_pkg::STAT_FLAG]) begin
        playback_finished_flag <= 1'b0;
      end
      interrupt_out_n_o <= !(playback_finished_flag && !mask_reg);
    end
  end

  // bus answer, one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_adr_i == hpmc_pkg::ADDR_CTRL) begin
        wb_dat_o[7:0] <= ctrl_reg;
      end else if (wb_adr_i == hpmc_pkg::ADDR_AMP) begin
        wb_dat_o[7:0] <= direct_amplitude;
      end else if (wb_adr_i == hpmc_pkg::ADDR_SEQ) begin
        wb_dat_o[9:0] <= {playback_repeat, playback_go, selected_sequence_loops,
                          selected_sequence_id};
      end else if (wb_adr_i == hpmc_pkg::ADDR_THR) begin
        wb_dat_o[7:0] <= zero_drive_duty_threshold;
      end else if (wb_adr_i == hpmc_pkg::ADDR_STAT) begin
        wb_dat_o[hpmc_pkg::STAT_FLAG] <= playback_finished_flag;
        wb_dat_o[hpmc_pkg::STAT_INACT] <= state_reg != hpmc_pkg::ST_WAKE
          && state_reg != hpmc_pkg::ST_DRIVE;
        wb_dat_o[hpmc_pkg::STAT_STATE_LSB +: 2] <= state_reg;
        wb_dat_o[hpmc_pkg::STAT_DUTY_LSB +: 8] <= duty;
      end else if (wb_adr_i == hpmc_pkg::ADDR_MASK) begin
        wb_dat_o[0] <= mask_reg;
      end else if (wb_adr_i == hpmc_pkg::ADDR_MEMCTL) begin
        wb_dat_o[15:0] <= {1'b0, hpmc_pkg::PATTERN_BASE, 7'h00, pattern_store_unlock};
      end else if (wb_adr_i == hpmc_pkg::ADDR_MEMADR) begin
        wb_dat_o[6:0] <= mem_addr_reg;
      end else if (wb_adr_i == hpmc_pkg::ADDR_MEMDAT) begin
        wb_dat_o[7:0] <= mem[mem_addr_reg];
      end
    end
  end

  // checks
  a_mode_zero_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_reg == hpmc_pkg::ST_DRIVE && mode == hpmc_pkg::MODE_INACTIVE
    |=> state_reg inside {hpmc_pkg::ST_IDLE, hpmc_pkg::ST_STANDBY})
    else $error("mode zero did not stop drive");
  a_wake_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_reg == hpmc_pkg::ST_DRIVE)
    |-> $past(state_reg) == hpmc_pkg::ST_WAKE && $past(wake_cnt_reg) == 17'h0)
    else $error("drive entered before wake time");
  a_irq_follows_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> interrupt_out_n_o == !($past(playback_finished_flag) && !$past(mask_reg)))
    else $error("interrupt does not follow flag and mask");
  a_zero_direct_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_reg == hpmc_pkg::ST_DRIVE && mode == hpmc_pkg::MODE_DIRECT
    && direct_amplitude == 8'h00 && brake_cnt_reg == 17'h0
    |=> !drive_en_o && state_reg == hpmc_pkg::ST_DRIVE)
    else $error("zero direct amplitude left stage on or left drive");
  a_locked_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wr0 && wb_adr_i == hpmc_pkg::ADDR_MEMDAT && !pattern_store_unlock
    |=> $stable(mem_addr_reg))
    else $error("locked store accepted a write");
  a_go_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_reg == hpmc_pkg::ST_IDLE && mode == hpmc_pkg::MODE_REG_PLAY
    && !playback_go |=> state_reg != hpmc_pkg::ST_WAKE)
    else $error("register playback started without go");
  a_pwm_threshold: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state_reg == hpmc_pkg::ST_DRIVE && mode == hpmc_pkg::MODE_PWM && !accel_en
    && duty < zero_drive_duty_threshold && brake_cnt_reg == 17'h0 |=> drive_level_o == 8'h00)
    else $error("duty below threshold gave nonzero drive");
  a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    done_evt |=> playback_finished_flag ##1 !interrupt_out_n_o || mask_reg)
    else $error("sequence end did not raise flag and interrupt");
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  c_direct_drive: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == hpmc_pkg::ST_DRIVE && mode == hpmc_pkg::MODE_DIRECT && drive_en_o);
  c_pwm_drive: cover property (@(posedge clk_i) disable iff (rst_i)
    state_reg == hpmc_pkg::ST_DRIVE && mode == hpmc_pkg::MODE_PWM && drive_en_o);
  c_seq_done: cover property (@(posedge clk_i) disable iff (rst_i) done_evt);
  c_brake: cover property (@(posedge clk_i) disable iff (rst_i) lra_phase_flip_o);
endmodule

/* verif/hpmc_pwm_src.sv */
// Purpose: stream source model driving a pwm wave onto the first trigger pin
// Assumes: shares the block clock, fixed 256-cycle period
// Notes: free running like a real pwm source; duty_i is high cycles per period
`timescale 1ns/100ps
module hpmc_pwm_src (
  input wire logic clk_i,
  input wire logic [7:0] duty_i,
  output logic pin_o
);
  logic [7:0] phase_reg = 8'h00;
  // period equal in length to the meter window, so each window sees exactly duty_i highs
  always_ff @(posedge clk_i) begin
    phase_reg <= phase_reg + 8'h01;
    pin_o <= (phase_reg < duty_i);
  end
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench of the playback mode controller
// Assumes: short wake and step counts, bench plays the host on the bus
// Notes: ce_i and byte enables are tied
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] duty = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat_o;
  logic ack, en, sgn, irq_n, flip, inv;
  logic [1:0] tpin = 2'b00;
  logic [7:0] lvl;
  wire pwm;
  int fail_count = 0;
  int num_checks = 0;
  int cyc_n = 0;
  always #5 clk_i = ~clk_i;
  hpmc_pwm_src i_src (.clk_i(clk_i), .duty_i(duty), .pin_o(pwm));
  hpmc_top #(.WAKE_CYCLES(20), .STEP_CYCLES(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .trigger_pins_i({tpin, pwm}), .drive_level_o(lvl), .drive_en_o(en),
    .drive_signed_o(sgn), .lra_phase_flip_o(flip), .erm_polarity_inv_o(inv),
    .interrupt_out_n_o(irq_n));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled
  // no local limit: only the hang guard ends a wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_en(input logic v);
    while (en !== v) @(posedge clk_i);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("irq_rst", {31'h0, irq_n}, 32'h1);
    bus(1'b0, hpmc_pkg::ADDR_THR, 32'h0); chk("thr_rst", rdat, 32'h10);
    bus(1'b0, hpmc_pkg::ADDR_CTRL, 32'h0); chk("ctrl_rst", rdat, 32'h0);
    bus(1'b0, 8'h3C, 32'h0); chk("unmapped", rdat, 32'h0);
    $display("reset test done");
    // upload while inactive, base read first
    bus(1'b1, hpmc_pkg::ADDR_MEMCTL, 32'h1);
    bus(1'b0, hpmc_pkg::ADDR_MEMCTL, 32'h0); chk("base", rdat, 32'h1001);
    bus(1'b1, hpmc_pkg::ADDR_MEMADR, 32'h11);
    bus(1'b1, hpmc_pkg::ADDR_MEMDAT, 32'h5A);
    bus(1'b1, hpmc_pkg::ADDR_MEMCTL, 32'h0);
    bus(1'b1, hpmc_pkg::ADDR_MEMADR, 32'h11);
    bus(1'b1, hpmc_pkg::ADDR_MEMDAT, 32'h77);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b1, hpmc_pkg::ADDR_MEMADR, 32'h11);
    bus(1'b0, hpmc_pkg::ADDR_MEMDAT, 32'h0); chk("store", rdat, 32'h5A);
    $display("store test done");
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h40);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h1); chk("wake_en", {31'h0, en}, 32'h0);
    wait_en(1'b1); chk("dir_lvl", {24'h0, lvl}, 32'h40);
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h90);
    @(posedge clk_i); chk("dir_new", {24'h0, lvl}, 32'h90);
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h0);
    bus(1'b0, hpmc_pkg::ADDR_STAT, 32'h0); chk("zero_st", {30'h0, rdat[5:4]}, 32'h3);
    chk("zero_en", {31'h0, en}, 32'h0);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h8);
    bus(1'b0, hpmc_pkg::ADDR_STAT, 32'h0); chk("stby", {30'h0, rdat[5:4]}, 32'h1);
    $display("direct test done");
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h1);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h3);
    repeat (40) @(posedge clk_i);
    chk("no_go", {31'h0, en}, 32'h0);
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h101);
    wait_en(1'b1); chk("play_lvl", {24'h0, lvl}, 32'h5A);
    wait_en(1'b0);
    repeat (4) @(posedge clk_i);
    chk("irq_lo", {31'h0, irq_n}, 32'h0);
    bus(1'b0, hpmc_pkg::ADDR_STAT, 32'h0); chk("done_st", rdat & 32'h31, 32'h1);
    bus(1'b1, hpmc_pkg::ADDR_STAT, 32'h1);
    @(posedge clk_i); chk("irq_clr", {31'h0, irq_n}, 32'h1);
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h101);
    wait_en(1'b1);
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h1);
    @(posedge clk_i); chk("abort", {31'h0, en}, 32'h0);
    $display("playback test done");
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h4);
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h1);
    tpin <= 2'b01;
    wait_en(1'b1); chk("pin_lvl", {24'h0, lvl}, 32'h5A);
    bus(1'b1, hpmc_pkg::ADDR_SEQ, 32'h301);
    repeat (14) @(posedge clk_i); chk("repeat", {31'h0, en}, 32'h1);
    wait_en(1'b0);
    bus(1'b1, hpmc_pkg::ADDR_STAT, 32'h1);
    $display("pin test done");
    duty <= 8'hC0;
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h2);
    wait_en(1'b1);
    repeat (600) @(posedge clk_i); chk("pwm_lvl", {24'h0, lvl}, 32'hC0);
    duty <= 8'h08;
    repeat (600) @(posedge clk_i); chk("pwm_thr", {24'h0, lvl}, 32'h0);
    duty <= 8'h88;
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h22);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h32);
    repeat (600) @(posedge clk_i); chk("pwm_mid", {24'h0, lvl}, 32'h0);
    chk("signed", {31'h0, sgn}, 32'h1);
    $display("pwm test done");
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h30);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h61);
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h0);
    @(posedge clk_i); chk("brk_flip", {31'h0, flip}, 32'h1);
    chk("brk_lvl", {24'h0, lvl}, 32'hFF);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'hE1);
    @(posedge clk_i); chk("brk_inv", {30'h0, inv, flip}, 32'h2);
    repeat (2010) @(posedge clk_i); chk("brk_end", {31'h0, en}, 32'h0);
    bus(1'b1, hpmc_pkg::ADDR_AMP, 32'h30);
    bus(1'b1, hpmc_pkg::ADDR_CTRL, 32'h5);
    @(posedge clk_i); chk("mode5", {31'h0, en}, 32'h0);
    bus(1'b0, hpmc_pkg::ADDR_STAT, 32'h0); chk("mode5_st", {30'h0, rdat[5:4]}, 32'h0);
    $display("brake test done");
    complete_run();
  end
endmodule
